// *** rtl/rlf_link_failover_controller.sv ***
/*
 Failover controller: keeps at most one of two master ports enabled.
 Assumes fault inputs are raw pins; responder straps are static levels.
 */
`timescale 1ns/10ps
module rlf_link_failover_controller (
   // Clock, reset, enable
   input  wire logic                        clk,
   input  wire logic                        rstn,
   input  wire logic                        ce,
   // Primary port faults: link loss, coll count, long coll, jabber, mau
   input  wire logic [rlf_pkg::NFAULT-1:0]  pri_fault,
   input  wire logic                        pri_remote_fail,
   input  wire logic                        pri_responder,
   // Secondary port faults, same five causes as the primary
   input  wire logic [rlf_pkg::NFAULT-1:0]  sec_fault,
   input  wire logic                        sec_remote_fail,
   input  wire logic                        sec_responder,
   // Port enables
   output logic                             pri_enable,
   output logic                             sec_enable,
   // Management status
   output logic                             pri_failed,
   output logic                             sec_failed,
   output rlf_pkg::rlf_state_type           link_state,
   output logic [rlf_pkg::CNT_W-1:0]        transition_count,
   output logic                             switch_event
);
   import rlf_pkg::*;

   logic pri_fail, sec_fail;
   rlf_state_type    st_r, st_nxt;
   logic [GAP_W-1:0] gap_r, gap_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic             pen_r, pen_nxt, sen_r, sen_nxt, ev_r, ev_nxt;
   logic             pf_r, pf_nxt, sf_r, sf_nxt;

   rlf_fault_sync u_pri (
      .clk        (clk),
      .rstn       (rstn),
      .ce         (ce),
      .fault_pins (pri_fault),
      .remote_fail(pri_remote_fail),
      .responder  (pri_responder),
      .fail       (pri_fail)
   );

   rlf_fault_sync u_sec (
      .clk        (clk),
      .rstn       (rstn),
      .ce         (ce),
      .fault_pins (sec_fault),
      .remote_fail(sec_remote_fail),
      .responder  (sec_responder),
      .fail       (sec_fail)
   );

   always_comb begin
      st_nxt  = st_r;
      gap_nxt = gap_r;
      cnt_nxt = cnt_r;
      ev_nxt  = 1'b0;
      pf_nxt  = pf_r;
      sf_nxt  = sf_r;
      if (ce) begin
         pf_nxt = pri_fail;
         sf_nxt = sec_fail;
         // count link state changes, one step per ce cycle even when both links change in it
         // Start-up settling of the synchronisers is not a transition
         if ((st_r != RLF_INIT)
             && ((pri_fail != pf_r) || (sec_fail != sf_r))) begin
            cnt_nxt = cnt_r + CNT_ONE;
         end
         case (st_r)
            // primary goes live only if healthy
            RLF_INIT: begin
               if (!pri_fail) begin
                  st_nxt = RLF_PRI;
                  ev_nxt = 1'b1;
               end else if (!sec_fail) begin
                  st_nxt  = RLF_TO_SEC;
                  gap_nxt = '0;
               end
            end
            RLF_PRI: begin
               if (pri_fail) begin
                  st_nxt  = RLF_TO_SEC;
                  gap_nxt = '0;
               end
            end
            // fixed gap, well inside the limit
            // primary already off, wait then enable secondary
            RLF_TO_SEC: begin
               if (gap_r == GAP_LAST) begin
                  st_nxt = sec_fail ? RLF_NONE : RLF_SEC;
                  ev_nxt = !sec_fail;
               end else begin
                  gap_nxt = gap_r + GAP_W'(1);
               end
            end
            // return only when the secondary fails
            RLF_SEC: begin
               if (sec_fail) begin
                  st_nxt  = RLF_TO_PRI;
                  gap_nxt = '0;
               end
            end
            RLF_TO_PRI: begin
               if (gap_r == GAP_LAST) begin
                  st_nxt = pri_fail ? RLF_NONE : RLF_PRI;
                  ev_nxt = !pri_fail;
               end else begin
                  gap_nxt = gap_r + GAP_W'(1);
               end
            end
            // Both failed: wait for either to recover, primary first
            RLF_NONE: begin
               if (!pri_fail) begin
                  st_nxt  = RLF_TO_PRI;
                  gap_nxt = GAP_LAST;
               end else if (!sec_fail) begin
                  st_nxt  = RLF_TO_SEC;
                  gap_nxt = GAP_LAST;
               end
            end
            default: st_nxt = RLF_INIT;
         endcase
      end
   end

   // enables decoded from one state, never both set
   // secondary off except in its own state
   always_comb begin
      pen_nxt = (st_nxt == RLF_PRI);
      sen_nxt = (st_nxt == RLF_SEC);
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_r  <= RLF_INIT;
         gap_r <= '0;
         cnt_r <= '0;
         pen_r <= 1'b0;
         sen_r <= 1'b0;
         ev_r  <= 1'b0;
         // Failed until the synchronisers hold real pin values
         pf_r  <= 1'b1;
         sf_r  <= 1'b1;
      end else begin
         st_r  <= st_nxt;
         gap_r <= gap_nxt;
         cnt_r <= cnt_nxt;
         pen_r <= pen_nxt;
         sen_r <= sen_nxt;
         ev_r  <= ev_nxt;
         pf_r  <= pf_nxt;
         sf_r  <= sf_nxt;
      end
   end

   assign pri_enable       = pen_r;
   assign sec_enable       = sen_r;
   assign pri_failed       = pf_r;
   assign sec_failed       = sf_r;
   assign link_state       = st_r;
   assign transition_count = cnt_r;
   // pulse on each change of active link
   assign switch_event     = ev_r;

   // Assertion helper: ce-cycles spent in the switchover gap,
   // kept apart from gap_r so that a broken gap counter is caught
   int unsigned sw_cyc_r, sw_cyc_nxt;

   always_comb begin
      sw_cyc_nxt = sw_cyc_r;
      if (st_r != RLF_TO_SEC) begin
         sw_cyc_nxt = '0;
      end else if (ce) begin
         sw_cyc_nxt = sw_cyc_r + 32'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         sw_cyc_r <= '0;
      end else begin
         sw_cyc_r <= sw_cyc_nxt;
      end
   end

   sequence pri_dropped;
      $fell(pen_r);
   endsequence

   property no_both_p;
      @(posedge clk) disable iff (!rstn) !(pen_r && sen_r);
   endproperty
   one_active_a: assert property (no_both_p)
      else $error("both links enabled");

   reset_state_a: assert property (@(posedge clk) disable iff (!rstn)
      $rose(rstn) |-> !sen_r)
      else $error("secondary active after reset");

   pri_first_a: assert property (@(posedge clk) disable iff (!rstn)
      $rose(sen_r) |-> !$past(pen_r))
      else $error("secondary enabled before primary off");

   gap_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      (pri_dropped ##0 ce) |-> !sen_r [*8])
      else $error("no gap before secondary");

   fail_drop_a: assert property (@(posedge clk) disable iff (!rstn)
      (ce && st_r == RLF_PRI && pri_fail) |=> !pen_r)
      else $error("primary kept after failure");

   switch_time_a: assert property (@(posedge clk) disable iff (!rstn)
      (st_r == RLF_TO_SEC) |-> (sw_cyc_r < 32'(MAX_CYC)))
      else $error("switch gap too long");

   no_return_a: assert property (@(posedge clk) disable iff (!rstn)
      (st_r == RLF_SEC && !sec_fail) |=> st_r != RLF_TO_PRI)
      else $error("primary returned early");

   count_step_a: assert property (@(posedge clk) disable iff (!rstn)
      (ce && st_r != RLF_INIT && (pri_fail != pf_r))
      |=> cnt_r == $past(cnt_r) + CNT_ONE)
      else $error("transition not counted");

   event_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
      ($rose(pen_r) || $rose(sen_r)) |-> ev_r)
      else $error("no event on switch");

   init_pri_a: assert property (@(posedge clk) disable iff (!rstn)
      (ce && st_r == RLF_INIT && !pri_fail) |=> pen_r)
      else $error("primary not enabled at init");
endmodule

// *** shared/rlf_pkg.sv ***
/*
 Constants and types for the redundant link pair failover controller.
 Assumes one 10 MHz clock domain for every user of the package.
 */
// Operation
// - After reset the primary link becomes active once it shows no failure.
// - After reset the secondary link is held inactive in standby.
// - Both master links are never enabled in the same cycle.
// - The primary link status is watched every cycle while it is in use; the code samples it only in cycles with ce high.
// - On a primary failure the primary is disabled before the secondary.
// - The switchover finishes well inside 10 ms of failure detection.
// - A repaired primary stays off until the secondary fails or reboot.
// - The state of both links is kept on outputs for management.
// - Each link state transition increments a management counter; the code adds only one when both links change in the same cycle.
// - With a nonresponder partner only local failures cause switchover.
// - Link loss, collisions, long collision, jabber or fault mean failure.
package rlf_pkg;
   localparam int CLK_HZ       = 10_000_000;
   // Gap between disabling one port and enabling the other
   localparam int GAP_US       = 4000;
   localparam int GAP_CYC      = (GAP_US * (CLK_HZ / 1_000_000));
   localparam int MAX_US       = 10000;
   localparam int MAX_CYC      = (MAX_US * (CLK_HZ / 1_000_000));
   localparam int GAP_W        = 16;
   localparam int CNT_W        = 16;
   localparam logic [GAP_W-1:0] GAP_LAST = GAP_W'(GAP_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
   localparam int NFAULT       = 5;

   typedef enum logic [2:0] {
      RLF_INIT, RLF_PRI, RLF_TO_SEC, RLF_SEC, RLF_TO_PRI, RLF_NONE
   } rlf_state_type;
endpackage

// *** rtl/rlf_fault_sync.sv ***
/*
 Two-flop synchroniser and fault merge for one master port.
 Assumes fault pins and the responder strap arrive asynchronous to clk.
 */
`timescale 1ns/10ps
module rlf_fault_sync (
   // Clock, reset, enable
   input  wire logic                       clk,
   input  wire logic                       rstn,
   input  wire logic                       ce,
   // Raw fault pins
   input  wire logic [rlf_pkg::NFAULT-1:0] fault_pins,
   input  wire logic                       remote_fail,
   input  wire logic                       responder,
   // Merged failure
   output logic                            fail
);
   import rlf_pkg::*;
   logic [NFAULT+1:0] s1_r, s1_nxt, s2_r, s2_nxt;

   always_comb begin
      s1_nxt = s1_r;
      s2_nxt = s2_r;
      if (ce) begin
         s1_nxt = {responder, remote_fail, fault_pins};
         s2_nxt = s1_r;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         // Assume failure until the pins have been sampled twice
         s1_r <= '1;
         s2_r <= '1;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
      end
   end

   // any local cause is a failure
   // remote report only counted with a responder
   assign fail = (|s2_r[NFAULT-1:0]) | (s2_r[NFAULT] & s2_r[NFAULT+1]);
endmodule

// *** verification/rlf_partner.sv ***
/*
 Remote responder or nonresponder port facing one master port.
 Assumes the bench cuts its receive link and straps its kind.
 */
`timescale 1ns/10ps
module rlf_partner (
   // Clock and commands
   input  wire logic clk,
   input  wire logic rx_cut,
   input  wire logic is_resp,
   // Lines to the master
   output logic      remote_fail,
   output logic      responder
);
   logic alt_r = 1'b0;
   always @(posedge clk) alt_r <= ~alt_r;
   // report own rx loss
   // Nonresponder drives a line that toggles every clock, so it wanders
   assign remote_fail = is_resp ? rx_cut : alt_r;
   assign responder   = is_resp;
endmodule

// *** verification/rlf_link_failover_controller_bench.sv ***
/*
 Self-checking bench for the failover controller.
 Assumes the fixed 4 ms gap, so two full switchovers are run.
 */
`timescale 1ns/10ps
module rlf_link_failover_controller_bench;
   import rlf_pkg::*;
   logic clk, rstn, ce, pri_cut, pri_rs, sec_rs, pri_rf, sec_rf, pri_r;
   logic sec_r, pri_enable, sec_enable, pri_failed, sec_failed, switch_event;
   logic [NFAULT-1:0] pri_fault, sec_fault;
   logic [CNT_W-1:0]  transition_count;
   rlf_state_type     link_state;
   int failures = 0, comparisons = 0, cycles = 0, n;
   rlf_partner rlf_partner_i (.clk(clk), .rx_cut(pri_cut),
      .is_resp(1'b1), .remote_fail(pri_rf), .responder(pri_r));
   rlf_partner rlf_partner_s (.clk(clk), .rx_cut(1'b0),
      .is_resp(1'b0), .remote_fail(sec_rf), .responder(sec_r));
   rlf_link_failover_controller rlf_link_failover_controller_i (.clk(clk),
      .rstn(rstn), .ce(ce), .pri_fault(pri_fault),
      .pri_remote_fail(pri_rf), .pri_responder(pri_r),
      .sec_fault(sec_fault), .sec_remote_fail(sec_rf),
      .sec_responder(sec_r), .pri_enable(pri_enable),
      .sec_enable(sec_enable), .pri_failed(pri_failed),
      .sec_failed(sec_failed), .link_state(link_state),
      .transition_count(transition_count), .switch_event(switch_event));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_st(input rlf_state_type got, input rlf_state_type exp);
      chk(16'(got), 16'(exp));
   endtask
   task automatic wait_en(input bit sec, input int lim);
      n = 0;
      while ((sec ? sec_enable : pri_enable) !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask
   always @(posedge clk) begin
      cycles++;
      // Two full gaps plus margin for the short scenarios
      if (cycles == 2 * GAP_CYC + 10000) begin
         failures++;
         end_of_test();
      end
   end
   always @(negedge clk) if (rstn === 1'b1) chk(pri_enable & sec_enable, 0);
   task automatic test_reset();
      chk(pri_enable, 0);
      chk(transition_count, 16'h0000);
      wait_en(0, 10);
      chk(n < 10, 1);
      chk(sec_enable, 0);
      chk_st(link_state, RLF_PRI);
      $display("test_reset done");
   endtask
   task automatic test_failover();
      pri_cut = 1'b1;
      repeat (5) @(negedge clk);
      chk(pri_enable, 0);
      chk(sec_enable, 0);
      chk(transition_count, 16'h0001);
      chk_st(link_state, RLF_TO_SEC);
      wait_en(1, MAX_CYC);
      chk(n >= 29990 && n < MAX_CYC, 1);
      chk(switch_event, 1);
      chk(pri_failed, 1);
      @(negedge clk);
      chk(switch_event, 0);
      chk_st(link_state, RLF_SEC);
      $display("test_failover done");
   endtask
   task automatic test_hold();
      pri_cut = 1'b0;
      repeat (20) @(negedge clk);
      chk(pri_enable, 0);
      chk(sec_enable, 1);
      chk(pri_failed, 0);
      chk(transition_count, 16'h0002);
      sec_fault = 5'h01;
      wait_en(0, MAX_CYC);
      chk(n < MAX_CYC, 1);
      chk(switch_event, 1);
      chk(sec_enable, 0);
      chk(sec_failed, 1);
      chk(transition_count, 16'h0003);
      $display("test_hold done");
   endtask
   task automatic restart();
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      wait_en(0, 10);
      chk(n < 10, 1);
      chk(sec_enable, 0);
      chk(pri_failed, 0);
      chk(transition_count, 16'h0000);
   endtask
   task automatic test_causes();
      for (int i = 0; i < NFAULT; i++) begin
         restart();
         pri_fault = NFAULT'(1) << i;
         repeat (4) @(negedge clk);
         chk(pri_failed, 1);
         chk(pri_enable, 0);
         chk(transition_count, 16'h0001);
         pri_fault = '0;
      end
      $display("test_causes done");
   endtask
   task automatic test_freeze();
      restart();
      ce = 1'b0;
      pri_fault = 5'h04;
      repeat (6) @(negedge clk);
      chk(pri_enable, 1);
      chk(pri_failed, 0);
      ce = 1'b1;
      repeat (4) @(negedge clk);
      chk(pri_enable, 0);
      chk(pri_failed, 1);
      pri_fault = '0;
      $display("test_freeze done");
   endtask
   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      pri_cut = 1'b0;
      pri_fault = '0;
      sec_fault = '0;
      repeat (10) @(negedge clk);
      rstn = 1'b1;
      test_reset();
      test_failover();
      test_hold();
      test_causes();
      test_freeze();
      end_of_test();
   end
endmodule
